// >>> design/scf_pkg.sv
// Shared constants and types for the serial command front end.
// Assumes one system clock; the serial clock is only sampled, never used as a clock.
package scf_pkg;

   // ------------------------------------------------------------
   // Command byte layout
   // ------------------------------------------------------------
   localparam int CMD_W = 8;
   localparam int CMD_GATE_POS = 7;
   localparam int CMD_DIR_POS = 6;
   localparam int CMD_SEL_HI = 5;
   localparam int CMD_SEL_LO = 3;
   localparam int CMD_CONT_POS = 2;
   localparam int CMD_PAYLOAD_BITS = 7;
   localparam logic [CMD_W-1:0] CMD_RESET_VAL = 8'h00;
   localparam logic [CMD_W-1:0] CMD_ENTER_CONT = 8'h5C;
   localparam logic [CMD_W-1:0] CMD_EXIT_CONT = 8'h58;

   // ------------------------------------------------------------
   // Register select codes
   // ------------------------------------------------------------
   typedef logic [2:0] scf_addr_type;
   localparam scf_addr_type ADDR_CMD_STATUS = 3'h0;
   localparam scf_addr_type ADDR_MODE = 3'h1;
   localparam scf_addr_type ADDR_CONFIG = 3'h2;
   localparam scf_addr_type ADDR_DATA = 3'h3;
   localparam scf_addr_type ADDR_ID = 3'h4;
   localparam scf_addr_type ADDR_IO = 3'h5;
   localparam scf_addr_type ADDR_OFFSET = 3'h6;
   localparam scf_addr_type ADDR_FULL_SCALE = 3'h7;

   // ------------------------------------------------------------
   // Register widths and sizes
   // ------------------------------------------------------------
   localparam int STATUS_W = 8;
   localparam int MODE_W = 16;
   localparam int CONFIG_W = 16;
   localparam int ID_W = 8;
   localparam int IO_W = 8;
   localparam int DATA_W_DEF = 24;
   localparam int FIFO_DEPTH_DEF = 16;

   // ------------------------------------------------------------
   // Resynchronising reset
   // ------------------------------------------------------------
   localparam int RESYNC_ONES = 32;
   localparam int ONES_W = 6;

   typedef enum logic [1:0]
   {
      ST_CMD = 2'h0,
      ST_WRITE = 2'h1,
      ST_READ = 2'h3,
      ST_CONT = 2'h2
   } scf_state_type;

   // Width in bits of the selected register; dw is the variant's wide size
   function automatic int scf_reg_width(scf_addr_type a, int dw);
      int w;
      w = dw;
      case (a)
         ADDR_CMD_STATUS: w = STATUS_W;
         ADDR_MODE: w = MODE_W;
         ADDR_CONFIG: w = CONFIG_W;
         ADDR_ID: w = ID_W;
         ADDR_IO: w = IO_W;
         default: w = dw;
      endcase
      return w;
   endfunction

endpackage

// >>> design/scf_stream_if.sv
// Valid/ready word channel between the front end and its result buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface scf_stream_if #(parameter int W = 24) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface // scf_stream_if

// >>> design/scf_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes pin is asynchronous to clk; edges are one-cycle pulses.
`timescale 1ns/10ps
module scf_sync #(parameter logic INIT = 1'b1)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic lvl,
   output logic rise,
   output logic fall
);
   import scf_pkg::*;

   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } scf_sync_state_type;

   scf_sync_state_type s_r;
   scf_sync_state_type s_nxt;
   logic agree;

   // Stage one feeds stage two only
   assign agree = (s_r.s2 == s_r.s3);

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.s1 = pin;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      if (agree)
      begin
         s_nxt.lvl = s_r.s3;
      end
      if (rst)
      begin
         s_nxt = {INIT, INIT, INIT, INIT};
      end
   end

   always_ff @(posedge clk)
   begin
      s_r <= s_nxt;
   end

   assign lvl = s_r.lvl;
   assign rise = agree && s_r.s3 && !s_r.lvl;
   assign fall = agree && !s_r.s3 && s_r.lvl;
endmodule // scf_sync

// >>> design/scf_fifo.sv
// Result buffer: parameterised FIFO with valid/ready on both sides.
// Assumes single clock; flush empties it in one cycle.
`timescale 1ns/10ps
module scf_fifo #(parameter int W = 24, parameter int DEPTH = 16)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   scf_stream_if.snk wr_port,
   scf_stream_if.src rd_port
);
   import scf_pkg::*;

   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } scf_fifo_state_type;

   scf_fifo_state_type s_r;
   scf_fifo_state_type s_nxt;
   logic push;
   logic pop;

   assign wr_port.ready = (s_r.cnt != (AW+1)'(DEPTH));
   assign rd_port.valid = (s_r.cnt != '0);
   assign rd_port.data = s_r.mem[s_r.rp];
   assign push = wr_port.valid && wr_port.ready;
   assign pop = rd_port.valid && rd_port.ready;

   always_comb
   begin
      s_nxt = s_r;
      if (push)
      begin
         s_nxt.mem[s_r.wp] = wr_port.data;
         s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
      end
      if (pop)
      begin
         s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
      end
      case ({push, pop})
         2'h2: s_nxt.cnt = s_r.cnt + 1'b1;
         2'h1: s_nxt.cnt = s_r.cnt - 1'b1;
         default: s_nxt.cnt = s_r.cnt;
      endcase
      if (rst || flush)
      begin
         s_nxt.wp = '0;
         s_nxt.rp = '0;
         s_nxt.cnt = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      s_r <= s_nxt;
   end
endmodule // scf_fifo

// >>> design/scf_front_end.sv
// Serial command front end of a sigma-delta converter: command byte, register
// transfers, continuous result read and the long-ones resynchronising reset.
// Assumes sclk/din come from the host pins; register contents live outside.
`timescale 1ns/10ps
module scf_front_end #(
   parameter int DW = scf_pkg::DATA_W_DEF,
   parameter int FIFO_DEPTH = scf_pkg::FIFO_DEPTH_DEF
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   output logic rdy_n,
   output logic cont_mode,
   output logic part_reset,
   output logic [scf_pkg::CMD_W-1:0] command_byte,
   output logic reg_wr_valid,
   output scf_pkg::scf_addr_type reg_wr_addr,
   output logic [DW-1:0] reg_wr_data,
   output scf_pkg::scf_addr_type reg_rd_addr,
   input wire logic [DW-1:0] reg_rd_data,
   input wire logic conv_valid,
   output logic conv_ready,
   input wire logic [DW-1:0] conv_data
);
   import scf_pkg::*;

   localparam int NB_W = $clog2(DW+1);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed
   {
      scf_state_type st;
      logic [2:0] cbit;
      logic [CMD_PAYLOAD_BITS-2:0] csh;
      logic [CMD_W-1:0] cmd;
      logic [NB_W-1:0] nbit;
      logic busy;
      logic load;
      logic [DW-1:0] osh;
      logic [DW-1:0] last;
      logic dout;
      logic [ONES_W-1:0] ones;
      logic wr_v;
      scf_addr_type wr_a;
      logic [DW-1:0] wr_d;
      scf_addr_type rd_a;
      logic srst;
   } scf_fe_state_type;

   scf_fe_state_type s_r;
   scf_fe_state_type s_nxt;

   logic sclk_lvl;
   logic sclk_rise;
   logic sclk_fall;
   logic din_lvl;
   logic pop;
   logic [CMD_W-1:0] cmd_in;
   logic cmd_dir;
   scf_addr_type cmd_sel;
   scf_addr_type xfer_sel;
   logic cmd_cont;
   int xfer_w;
   int rd_w;

   scf_stream_if #(.W(DW)) res_in ();
   scf_stream_if #(.W(DW)) res_out ();

   // ------------------------------------------------------------
   // Pin sampling and result buffer
   // ------------------------------------------------------------
   scf_sync #(.INIT(1'b1)) u_sclk_sync
   (
      .clk(mclk),
      .rst(sys_rst),
      .pin(sclk),
      .lvl(sclk_lvl),
      .rise(sclk_rise),
      .fall(sclk_fall)
   );

   // Reset value low so a pin stuck idle does not count as ones
   scf_sync #(.INIT(1'b0)) u_din_sync
   (
      .clk(mclk),
      .rst(sys_rst),
      .pin(din),
      .lvl(din_lvl),
      .rise(),
      .fall()
   );

   assign res_in.valid = conv_valid;
   assign res_in.data = conv_data;
   assign conv_ready = res_in.ready;
   assign res_out.ready = pop;

   // A full buffer stalls the converter side through conv_ready
   scf_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_result_fifo
   (
      .clk(mclk),
      .rst(sys_rst),
      .flush(s_r.srst),
      .wr_port(res_in),
      .rd_port(res_out)
   );

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   assign cmd_in = {1'b0, s_r.csh, din_lvl};
   assign cmd_dir = cmd_in[CMD_DIR_POS];
   assign cmd_sel = cmd_in[CMD_SEL_HI:CMD_SEL_LO];
   assign cmd_cont = cmd_in[CMD_CONT_POS];
   assign xfer_sel = s_r.cmd[CMD_SEL_HI:CMD_SEL_LO];
   assign xfer_w = scf_reg_width(xfer_sel, DW);
   assign rd_w = scf_reg_width(s_r.rd_a, DW);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.wr_v = 1'b0;
      s_nxt.srst = 1'b0;
      s_nxt.load = 1'b0;
      pop = 1'b0;

      // Read data is captured one cycle after the address is presented
      if (s_r.load)
      begin
         s_nxt.nbit = '0;
         if (s_r.rd_a == ADDR_DATA)
         begin
            if (res_out.valid)
            begin
               pop = 1'b1;
               s_nxt.osh = res_out.data;
               s_nxt.last = res_out.data;
            end
            else
            begin
               s_nxt.osh = s_r.last;
            end
         end
         else
         begin
            // Status comes from outside at address zero, never the command byte
            s_nxt.osh = DW'(reg_rd_data << (DW - rd_w));
         end
      end

      // Output changes on falling serial clock
      if (sclk_fall)
      begin
         if (s_r.st == ST_READ || (s_r.st == ST_CONT && s_r.busy))
         begin
            s_nxt.dout = s_r.osh[DW-1];
            s_nxt.osh = {s_r.osh[DW-2:0], 1'b0};
         end
         else if (s_r.st == ST_CONT && res_out.valid)
         begin
            pop = 1'b1;
            s_nxt.busy = 1'b1;
            s_nxt.nbit = '0;
            s_nxt.last = res_out.data;
            s_nxt.dout = res_out.data[DW-1];
            s_nxt.osh = {res_out.data[DW-2:0], 1'b0};
         end
      end

      // Input sampled on rising serial clock
      if (sclk_rise)
      begin
         // Runs in every state, continuous read included
         if (din_lvl)
         begin
            if (s_r.ones != ONES_W'(RESYNC_ONES))
            begin
               s_nxt.ones = s_r.ones + 1'b1;
            end
         end
         else
         begin
            s_nxt.ones = '0;
         end

         case (s_r.st)
            ST_WRITE:
            begin
               s_nxt.osh = {s_r.osh[DW-2:0], din_lvl};
               s_nxt.nbit = s_r.nbit + 1'b1;
               if (s_r.nbit == NB_W'(xfer_w - 1))
               begin
                  s_nxt.wr_v = 1'b1;
                  s_nxt.wr_d = {s_r.osh[DW-2:0], din_lvl};
                  s_nxt.st = ST_CMD;
               end
            end
            ST_READ:
            begin
               s_nxt.nbit = s_r.nbit + 1'b1;
               if (s_r.nbit == NB_W'(rd_w - 1))
               begin
                  s_nxt.st = ST_CMD;
               end
            end
            default:
            begin
               if (s_r.st == ST_CONT && s_r.busy)
               begin
                  s_nxt.nbit = s_r.nbit + 1'b1;
                  if (s_r.nbit == NB_W'(DW - 1))
                  begin
                     s_nxt.busy = 1'b0;
                  end
               end
            end
         endcase

         // Command receiver: idle and continuous read both listen
         if (s_r.st == ST_CMD || s_r.st == ST_CONT)
         begin
            if (s_r.cbit == '0)
            begin
               // Gate bit high holds the counter at the first position
               if (!din_lvl)
               begin
                  s_nxt.cbit = 3'h1;
               end
            end
            else
            begin
               s_nxt.csh = {s_r.csh[CMD_PAYLOAD_BITS-3:0], din_lvl};
               if (s_r.cbit == 3'(CMD_PAYLOAD_BITS))
               begin
                  s_nxt.cbit = '0;
                  if (s_r.st == ST_CONT)
                  begin
                     // Exit only while a result is pending or still being shifted out
                     if (cmd_in == CMD_EXIT_CONT && (res_out.valid || s_r.busy))
                     begin
                        s_nxt.cmd = cmd_in;
                        s_nxt.busy = 1'b0;
                        s_nxt.st = ST_CMD;
                     end
                  end
                  else
                  begin
                     s_nxt.cmd = cmd_in;
                     s_nxt.nbit = '0;
                     if (!cmd_dir)
                     begin
                        // Writing address zero is a command only; wait for the next
                        if (cmd_sel != ADDR_CMD_STATUS)
                        begin
                           s_nxt.wr_a = cmd_sel;
                           s_nxt.st = ST_WRITE;
                        end
                     end
                     else if (cmd_sel == ADDR_DATA && cmd_cont)
                     begin
                        s_nxt.busy = 1'b0;
                        s_nxt.st = ST_CONT;
                     end
                     else
                     begin
                        s_nxt.rd_a = cmd_sel;
                        s_nxt.load = 1'b1;
                        s_nxt.st = ST_READ;
                     end
                  end
               end
               else
               begin
                  s_nxt.cbit = s_r.cbit + 1'b1;
               end
            end
         end

         // Long run of ones: whole part back to its reset state
         if (din_lvl && s_r.ones == ONES_W'(RESYNC_ONES - 1))
         begin
            s_nxt = '0;
            s_nxt.st = ST_CMD;
            s_nxt.cmd = CMD_RESET_VAL;
            s_nxt.ones = ONES_W'(RESYNC_ONES);
            s_nxt.srst = 1'b1;
            s_nxt.dout = 1'b1;
            pop = 1'b0;
         end
      end

      // Outside a shift the pin shows ready, low while a result waits
      if (!(s_nxt.st == ST_READ || (s_nxt.st == ST_CONT && s_nxt.busy)))
      begin
         s_nxt.dout = !res_out.valid;
      end

      if (sys_rst)
      begin
         s_nxt = '0;
         s_nxt.st = ST_CMD;
         s_nxt.cmd = CMD_RESET_VAL;
         s_nxt.dout = 1'b1;
         pop = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      s_r <= s_nxt;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign dout = s_r.dout;
   assign rdy_n = !res_out.valid;
   assign cont_mode = (s_r.st == ST_CONT);
   assign part_reset = s_r.srst;
   assign command_byte = s_r.cmd;
   assign reg_wr_valid = s_r.wr_v;
   assign reg_wr_addr = s_r.wr_a;
   assign reg_wr_data = s_r.wr_d;
   assign reg_rd_addr = s_r.rd_a;
endmodule // scf_front_end

// >>> bench/scf_host_model.sv
// Host serial controller model: makes sclk, drives din, samples dout.
// Assumes the bench calls xfer; sclk stands high between frames.
`timescale 1ns/10ps
module scf_host_model
(
   output logic sclk,
   output logic din,
   input wire logic dout
);
   initial
   begin
      sclk = 1'b1;
      din = 1'b0;
   end

   // ------------------------------------------------------------
   // One frame of n bits, rx right-aligned
   // ------------------------------------------------------------
   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sclk = 1'b0;
         din = tx[i];
         #100;
         sclk = 1'b1;
         // Mid high phase: bit has settled after the filtered fall, and the filtered rise has not yet replaced it
         #50;
         rx = {rx[30:0], dout};
         #50;
      end
      // Released line: stale level must never look valid
      din = ~din;
   endtask
endmodule // scf_host_model

// >>> bench/scf_front_end_checker.sv
// Port-level assertions for the serial command front end.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/10ps
module scf_front_end_checker
   import scf_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic dout,
   input wire logic rdy_n,
   input wire logic cont_mode,
   input wire logic part_reset,
   input wire logic [scf_pkg::CMD_W-1:0] command_byte,
   input wire logic reg_wr_valid,
   input wire scf_pkg::scf_addr_type reg_wr_addr,
   input wire logic conv_valid,
   input wire logic conv_ready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // ------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------
   sequence s_push;
      conv_valid && conv_ready && !part_reset && !$past(part_reset);
   endsequence
   sequence s_wr_pulse;
      reg_wr_valid ##1 !reg_wr_valid;
   endsequence

   AST_RESET_IDLE: assert property ($fell(sys_rst) |-> command_byte == CMD_RESET_VAL && !cont_mode
      && rdy_n && dout && !part_reset) else $error("Outputs not idle after reset");
   AST_GATE_BIT: assert property (command_byte[CMD_GATE_POS] == 1'b0)
      else $error("Command gate bit stored as one");
   AST_PR_PULSE: assert property (part_reset |=> !part_reset)
      else $error("Part reset longer than one cycle");
   AST_PR_CLEAR: assert property (part_reset |-> command_byte == CMD_RESET_VAL && !cont_mode)
      else $error("Part reset left command or mode set");
   AST_WR_ONE: assert property (reg_wr_valid |-> s_wr_pulse)
      else $error("Write pulse longer than one cycle");
   AST_WR_CMD: assert property (reg_wr_valid |-> !command_byte[CMD_DIR_POS]
      && reg_wr_addr == command_byte[CMD_SEL_HI:CMD_SEL_LO] && reg_wr_addr != ADDR_CMD_STATUS)
      else $error("Write does not match command");
   AST_RDY_PUSH: assert property (s_push |=> !rdy_n)
      else $error("Ready not low with result held");
   AST_CONT_ENTRY: assert property ($rose(cont_mode) |-> command_byte == CMD_ENTER_CONT)
      else $error("Continuous mode without enter command");
   AST_CONT_EXIT: assert property ($fell(cont_mode) |-> command_byte == CMD_EXIT_CONT
      || command_byte == CMD_RESET_VAL) else $error("Continuous mode left without cause");
endmodule // scf_front_end_checker

// >>> bench/tb_scf_front_end.sv
// Self-checking bench for the serial command front end.
// Assumes the host model drives the link; bench stands in for registers.
`timescale 1ns/10ps
module tb_scf_front_end;
   import scf_pkg::*;
   localparam int DW = DATA_W_DEF;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic conv_valid = 1'b0;
   logic [DW-1:0] conv_data = '0;
   logic sclk, din, dout, rdy_n, cont_mode, part_reset, reg_wr_valid, conv_ready;
   logic [CMD_W-1:0] command_byte;
   scf_addr_type reg_wr_addr, reg_rd_addr, wr_a;
   logic [DW-1:0] reg_wr_data, reg_rd_data, wr_d;
   logic [31:0] rx;
   int mismatches = 0, n_compared = 0, wr_cnt = 0, pr_cnt = 0, w;

   always #12.5 mclk = ~mclk;
   // Register stand-in: value depends only on the select
   assign reg_rd_data = DW'({8{reg_rd_addr}});

   scf_front_end #(.DW(DW), .FIFO_DEPTH(FIFO_DEPTH_DEF)) scf_front_end_inst (.mclk(mclk), .sys_rst(sys_rst),
      .sclk(sclk), .din(din), .dout(dout), .rdy_n(rdy_n), .cont_mode(cont_mode), .part_reset(part_reset),
      .command_byte(command_byte), .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
      .conv_valid(conv_valid), .conv_ready(conv_ready), .conv_data(conv_data));
   scf_host_model scf_host_model_inst (.sclk(sclk), .din(din), .dout(dout));

   always @(posedge mclk)
   begin
      if (reg_wr_valid)
      begin
         wr_cnt++;
         wr_a = reg_wr_addr;
         wr_d = reg_wr_data;
      end
      if (part_reset)
         pr_cnt++;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic txn(input logic [7:0] c, input logic [31:0] d, input int n);
      scf_host_model_inst.xfer(32'(c), 8, rx);
      if (n > 0)
         scf_host_model_inst.xfer(d, n, rx);
      repeat (8) @(negedge mclk);
   endtask
   function automatic logic [31:0] regv(int a, int n);
      return 32'({8{3'(a)}}) & ((32'h1 << n) - 1);
   endfunction
   function automatic logic [31:0] word(int j);
      return {8'h00, 4'(j), 20'h5A5A5};
   endfunction
   task automatic complete_run();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge mclk);
      mismatches++;
      complete_run();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (4) @(negedge mclk);
      chk("command_byte", 8'h00, command_byte);
      chk("dout", 1, dout);
      // 31 ones are gate bits only: no reset, command follows
      scf_host_model_inst.xfer(32'h7FFFFFFF, 31, rx);
      txn(8'h48, 0, 16);
      chk("command_byte", 8'h48, command_byte);
      chk("mode read", regv(1, 16), rx);
      chk("part_reset count", 0, pr_cnt);
      for (int a = 0; a < 8; a++)
      begin
         if (a != 3)
         begin
            w = (a == 1 || a == 2) ? 16 : (a >= 6) ? DW : 8;
            txn({2'b01, 3'(a), 3'b000}, 0, w);
            chk("read addr", a, reg_rd_addr);
            chk("read value", regv(a, w), rx);
            if (a != 0)
            begin
               txn({2'b00, 3'(a), 3'b000}, 32'hC3A5F0 & ((32'h1 << w) - 1), w);
               chk("write addr", a, wr_a);
               chk("write data", 32'hC3A5F0 & ((32'h1 << w) - 1), 32'(wr_d));
            end
         end
      end
      // Write to select zero carries no data: next byte is a command
      w = wr_cnt;
      txn(8'h00, 0, 0);
      txn(8'h60, 0, 8);
      chk("id read", regv(4, 8), rx);
      chk("write count", w, wr_cnt);
      // Fill the result buffer until it refuses
      for (int j = 0; j < 17; j++)
      begin
         conv_valid = 1'b1;
         conv_data = DW'(word(j));
         @(negedge mclk);
      end
      chk("conv_ready full", 0, conv_ready);
      conv_valid = 1'b0;
      chk("rdy_n", 0, rdy_n);
      chk("dout ready", 0, dout);
      txn(CMD_EXIT_CONT, 0, DW);
      chk("data read", word(0), rx);
      txn(CMD_ENTER_CONT, 0, 0);
      chk("cont_mode", 1, cont_mode);
      for (int j = 1; j < 3; j++)
      begin
         scf_host_model_inst.xfer(0, DW, rx);
         chk("cont read", word(j), rx);
      end
      chk("cont_mode hold", 1, cont_mode);
      txn(CMD_EXIT_CONT, 0, 0);
      chk("cont_mode exit", 0, cont_mode);
      txn(CMD_ENTER_CONT, 0, 0);
      scf_host_model_inst.xfer(32'hFFFFFFFF, 32, rx);
      repeat (8) @(negedge mclk);
      chk("part_reset count", 1, pr_cnt);
      chk("cont_mode reset", 0, cont_mode);
      chk("command_byte", 8'h00, command_byte);
      chk("rdy_n flushed", 1, rdy_n);
      txn(8'h48, 0, 16);
      chk("mode read", regv(1, 16), rx);
      complete_run();
   end
endmodule // tb_scf_front_end

bind scf_front_end scf_front_end_checker scf_front_end_checker_inst (.mclk(mclk), .sys_rst(sys_rst),
   .dout(dout), .rdy_n(rdy_n), .cont_mode(cont_mode), .part_reset(part_reset), .command_byte(command_byte),
   .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr), .conv_valid(conv_valid), .conv_ready(conv_ready));
